/* rtl/fcm_bus_cycle.sv */
// one flash bus cycle engine: a read or a write on the parallel pins
// assumes a divider pulse paces each phase; data in is already synchronised
`timescale 1ns/1ps
module fcm_bus_cycle
    import fcm_pkg::*;
#(
    parameter int PHASE = FCM_PHASE_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire fcm_cycle_t cyc,
    input wire logic [FCM_DW-1:0] din,
    output fcm_pins_t pins,
    output logic done,
    output logic [FCM_DW-1:0] rdata
);
    // ****************************************
    // phase divider and sequencer
    // ****************************************
    typedef enum logic [1:0] {
        FCM_C_IDLE = 2'b00,
        FCM_C_SETUP = 2'b01,
        FCM_C_STROBE = 2'b10,
        FCM_C_HOLD = 2'b11
    } fcm_cst_t;
    fcm_cst_t st_r;
    logic [7:0] div_r;
    logic tick;
    fcm_cycle_t cyc_r;
    assign tick = (div_r == 8'(PHASE - 1));
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r <= FCM_C_IDLE;
            div_r <= 8'h00;
            cyc_r <= '0;
            pins <= '{ceN: 1'b1, weN: 1'b1, oeN: 1'b1, default: '0};
            done <= 1'b0;
            rdata <= '0;
        end else begin
            done <= 1'b0;
            div_r <= (st_r == FCM_C_IDLE || tick) ? 8'h00 : div_r + 8'h01;
            case (st_r)
                FCM_C_IDLE: if (start) begin
                    // address settles while both strobes are high
                    cyc_r <= cyc;
                    pins.addr <= cyc.addr;
                    pins.dout <= cyc.data;
                    pins.doe <= !cyc.rd;
                    pins.ceN <= 1'b0;
                    st_r <= FCM_C_SETUP;
                end
                FCM_C_SETUP: if (tick) begin
                    // chip select fell first, so the write strobe fall latches the address
                    pins.weN <= cyc_r.rd;
                    pins.oeN <= !cyc_r.rd;
                    st_r <= FCM_C_STROBE;
                end
                FCM_C_STROBE: if (tick) begin
                    // write strobe rises before chip select: it latches the data
                    pins.weN <= 1'b1;
                    pins.oeN <= 1'b1;
                    if (cyc_r.rd) begin
                        rdata <= din;
                    end
                    st_r <= FCM_C_HOLD;
                end
                FCM_C_HOLD: if (tick) begin
                    pins.ceN <= 1'b1;
                    pins.doe <= 1'b0;
                    done <= 1'b1;
                    st_r <= FCM_C_IDLE;
                end
                default: st_r <= FCM_C_IDLE;
            endcase
        end
    end
endmodule : fcm_bus_cycle

/* rtl/fcm_host.sv */
// host controller issuing command sequences to a parallel flash
// assumes software on the plain register port; flash pins asynchronous to clk
`timescale 1ns/1ps
module fcm_host
    import fcm_pkg::*;
#(
    parameter logic [FCM_AW-1:0] UNLOCK1_A = FCM_DEF_UNLOCK1_A,
    parameter logic [FCM_AW-1:0] UNLOCK2_A = FCM_DEF_UNLOCK2_A,
    parameter logic [FCM_DW-1:0] UNLOCK1_D = FCM_DEF_UNLOCK1_D,
    parameter logic [FCM_DW-1:0] UNLOCK2_D = FCM_DEF_UNLOCK2_D,
    parameter logic [FCM_DW-1:0] IDENT_D = FCM_DEF_IDENT_D,
    parameter logic [FCM_DW-1:0] SUSPEND_D = FCM_DEF_SUSPEND_D
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdata,
    output logic flashCeN,
    output logic flashWeN,
    output logic flashOeN,
    output logic [FCM_AW-1:0] flashAddr,
    output logic [FCM_DW-1:0] flashDqOut,
    output logic flashDqOe,
    input wire logic [FCM_DW-1:0] flashDqIn
);
    // ****************************************
    // input synchroniser and registers
    // ****************************************
    logic [FCM_DW-1:0] dqMeta_r, dqSync_r;
    logic [FCM_AW-1:0] addr_r;
    logic [FCM_DW-1:0] data_r, rdata_r;
    fcm_mode_t mode_r, baseMode_r;
    logic busy_r, tmo_r, abt_r, err_r, inOp_r;
    logic [2:0] step_r, steps_r;
    logic [3:0] op_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dqMeta_r <= '0;
            dqSync_r <= '0;
        end else begin
            dqMeta_r <= flashDqIn;
            dqSync_r <= dqMeta_r;
        end
    end
    // ****************************************
    // sequence table
    // ****************************************
    function automatic fcm_cycle_t seq_cycle(input logic [3:0] op, input logic [2:0] step,
                                             input logic [FCM_AW-1:0] a,
                                             input logic [FCM_DW-1:0] d);
        fcm_cycle_t c;
        c = '{addr: a, data: d, rd: 1'b0};
        case (op)
            FCM_OP_READ: c.rd = 1'b1;
            FCM_OP_WRITE: c = c;
            FCM_OP_RESET: c.data = FCM_RESET_DATA;
            FCM_OP_QUERY: c = '{addr: FCM_QUERY_ADDR, data: FCM_QUERY_DATA, rd: 1'b0};
            FCM_OP_SUSPEND: c.data = SUSPEND_D;
            default: begin
                // unlock pair, then ident or abort-reset command
                case (step)
                    3'h0: c = '{addr: UNLOCK1_A, data: UNLOCK1_D, rd: 1'b0};
                    3'h1: c = '{addr: UNLOCK2_A, data: UNLOCK2_D, rd: 1'b0};
                    default: c = '{addr: UNLOCK1_A, data: (op == FCM_OP_IDENT) ? IDENT_D
                                   : FCM_RESET_DATA, rd: 1'b0};
                endcase
            end
        endcase
        return c;
    endfunction : seq_cycle
    // ****************************************
    // command acceptance
    // ****************************************
    logic cmdWr, cycDone, start_r, illegal;
    logic [3:0] newOp;
    logic [FCM_DW-1:0] cycRdata;
    fcm_pins_t pins;
    fcm_cycle_t curCyc;
    assign cmdWr = regWr && (regAddr == FCM_REG_CMD);
    assign newOp = regWdata[3:0];
    // identify only from a read mode; commands other than read blocked while an embedded op runs
    assign illegal = (newOp == FCM_OP_IDENT && mode_r != FCM_M_READ && mode_r != FCM_M_SUSP)
                     || (inOp_r && newOp != FCM_OP_READ)
                     || (abt_r && newOp != FCM_OP_ABORT_RST && newOp != FCM_OP_READ)
                     || (newOp > FCM_OP_SUSPEND);
    assign curCyc = seq_cycle(op_r, step_r, addr_r, data_r);
    // either byte lane may carry a status flag, so both lanes are watched
    logic pollTmo, pollAbt;
    assign pollTmo = cycRdata[FCM_TMO_BIT_LO] || cycRdata[FCM_TMO_BIT_HI];
    assign pollAbt = cycRdata[FCM_ABT_BIT_LO] || cycRdata[FCM_ABT_BIT_HI];
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            addr_r <= '0;
            data_r <= '0;
            rdata_r <= '0;
            mode_r <= FCM_M_READ;
            baseMode_r <= FCM_M_READ;
            busy_r <= 1'b0;
            tmo_r <= 1'b0;
            abt_r <= 1'b0;
            err_r <= 1'b0;
            inOp_r <= 1'b0;
            step_r <= 3'h0;
            steps_r <= 3'h0;
            op_r <= 4'h0;
            start_r <= 1'b0;
        end else begin
            start_r <= 1'b0;
            if (regWr && regAddr == FCM_REG_ADDR) addr_r <= regWdata[FCM_AW-1:0];
            if (regWr && regAddr == FCM_REG_DATA) data_r <= regWdata[FCM_DW-1:0];
            if (regWr && regAddr == FCM_REG_MODE) inOp_r <= regWdata[0];
            if (regWr && regAddr == FCM_REG_STAT) err_r <= err_r & ~regWdata[FCM_STAT_ERR];
            if (cmdWr && !busy_r) begin
                if (illegal) begin
                    err_r <= 1'b1;
                end else begin
                    op_r <= newOp;
                    step_r <= 3'h0;
                    steps_r <= (newOp == FCM_OP_IDENT || newOp == FCM_OP_ABORT_RST) ? 3'h3
                               : 3'h1;
                    busy_r <= 1'b1;
                    start_r <= 1'b1;
                end
            end else if (busy_r && cycDone) begin
                if (step_r + 3'h1 < steps_r) begin
                    step_r <= step_r + 3'h1;
                    start_r <= 1'b1;
                end else begin
                    busy_r <= 1'b0;
                    case (op_r)
                        FCM_OP_READ: begin
                            rdata_r <= cycRdata;
                            // status flags from polling reads during an embedded op
                            if (inOp_r && pollTmo) tmo_r <= 1'b1;
                            if (inOp_r && pollAbt) abt_r <= 1'b1;
                        end
                        FCM_OP_RESET, FCM_OP_ABORT_RST: begin
                            // query falls back to its origin, else to read or suspend-read
                            mode_r <= (mode_r == FCM_M_QUERY) ? baseMode_r
                                      : (mode_r == FCM_M_IDENT) ? baseMode_r
                                      : (mode_r == FCM_M_SUSP) ? FCM_M_SUSP
                                      : FCM_M_READ;
                            if (mode_r == FCM_M_QUERY && baseMode_r == FCM_M_IDENT) begin
                                baseMode_r <= FCM_M_READ;
                            end
                            tmo_r <= 1'b0;
                            abt_r <= 1'b0;
                            inOp_r <= 1'b0;
                        end
                        FCM_OP_IDENT: begin
                            baseMode_r <= mode_r;
                            mode_r <= FCM_M_IDENT;
                        end
                        FCM_OP_QUERY: begin
                            baseMode_r <= (mode_r == FCM_M_IDENT) ? FCM_M_IDENT : mode_r;
                            mode_r <= FCM_M_QUERY;
                        end
                        FCM_OP_SUSPEND: mode_r <= FCM_M_SUSP;
                        default: mode_r <= mode_r;
                    endcase
                end
            end
        end
    end
    // ****************************************
    // pin engine
    // ****************************************
    fcm_bus_cycle u_cycle (
        .clk(clk),
        .nrst(nrst),
        .start(start_r),
        .cyc(curCyc),
        .din(dqSync_r),
        .pins(pins),
        .done(cycDone),
        .rdata(cycRdata)
    );
    assign flashCeN = pins.ceN;
    assign flashWeN = pins.weN;
    assign flashOeN = pins.oeN;
    assign flashAddr = pins.addr;
    assign flashDqOut = pins.dout;
    assign flashDqOe = pins.doe;
    // ****************************************
    // read port, one cycle latency
    // ****************************************
    logic [31:0] rdMux;
    assign rdMux = (regAddr == FCM_REG_ADDR) ? 32'(addr_r)
                 : (regAddr == FCM_REG_DATA) ? 32'(data_r)
                 : (regAddr == FCM_REG_STAT) ? {28'h0, err_r, abt_r, tmo_r, busy_r}
                 : (regAddr == FCM_REG_RDATA) ? 32'(rdata_r)
                 : (regAddr == FCM_REG_MODE) ? {28'h0, baseMode_r, mode_r[0] & 1'b0, inOp_r}
                   | {28'h0, 2'b00, 2'b00} | (32'(mode_r) << 4)
                 : 32'h0000_0000;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) regRdata <= 32'h0000_0000;
        else if (regRd) regRdata <= rdMux;
    end
endmodule : fcm_host

/* rtl/fcm_pkg.sv */
// package for the flash command host controller: bus layout, query map, command codes
// assumes a parallel flash with active-low chip select, write strobe and output enable
package fcm_pkg;
    localparam int FCM_AW = 24;
    localparam int FCM_DW = 16;
    // ****************************************
    // software port registers
    // ****************************************
    localparam logic [3:0] FCM_REG_ADDR = 4'h0;
    localparam logic [3:0] FCM_REG_DATA = 4'h1;
    localparam logic [3:0] FCM_REG_CMD = 4'h2;
    localparam logic [3:0] FCM_REG_STAT = 4'h3;
    localparam logic [3:0] FCM_REG_RDATA = 4'h4;
    localparam logic [3:0] FCM_REG_MODE = 4'h5;
    localparam int FCM_STAT_BUSY = 0;
    localparam int FCM_STAT_TMO = 1;
    localparam int FCM_STAT_ABT = 2;
    localparam int FCM_STAT_ERR = 3;
    // ****************************************
    // command opcodes of the command register
    // ****************************************
    localparam logic [3:0] FCM_OP_READ = 4'h0;
    localparam logic [3:0] FCM_OP_WRITE = 4'h1;
    localparam logic [3:0] FCM_OP_RESET = 4'h2;
    localparam logic [3:0] FCM_OP_IDENT = 4'h3;
    localparam logic [3:0] FCM_OP_QUERY = 4'h4;
    localparam logic [3:0] FCM_OP_ABORT_RST = 4'h5;
    localparam logic [3:0] FCM_OP_SUSPEND = 4'h6;
    // ****************************************
    // flash command values
    // ****************************************
    localparam logic [FCM_DW-1:0] FCM_RESET_DATA = 16'h00f0;
    localparam logic [FCM_DW-1:0] FCM_QUERY_DATA = 16'h0098;
    localparam logic [FCM_AW-1:0] FCM_QUERY_ADDR = 24'h000055;
    localparam logic [FCM_DW-1:0] FCM_DEF_UNLOCK1_D = 16'h00aa;
    localparam logic [FCM_DW-1:0] FCM_DEF_UNLOCK2_D = 16'h0055;
    localparam logic [FCM_AW-1:0] FCM_DEF_UNLOCK1_A = 24'h000555;
    localparam logic [FCM_AW-1:0] FCM_DEF_UNLOCK2_A = 24'h0002aa;
    localparam logic [FCM_DW-1:0] FCM_DEF_IDENT_D = 16'h0090;
    localparam logic [FCM_DW-1:0] FCM_DEF_SUSPEND_D = 16'h00b0;
    // ****************************************
    // extended query map the host expects
    // ****************************************
    localparam logic [FCM_AW-1:0] FCM_Q_PRI0 = 24'h000040;
    localparam logic [FCM_AW-1:0] FCM_Q_LAST = 24'h000050;
    localparam logic [FCM_DW-1:0] FCM_Q_P = 16'h5050;
    localparam logic [FCM_DW-1:0] FCM_Q_R = 16'h5252;
    localparam logic [FCM_DW-1:0] FCM_Q_I = 16'h4949;
    localparam logic [FCM_DW-1:0] FCM_Q_MAJ = 16'h3131;
    localparam logic [FCM_DW-1:0] FCM_Q_MIN = 16'h3333;
    localparam logic [FCM_DW-1:0] FCM_Q_UNLK = 16'h0808;
    localparam logic [FCM_DW-1:0] FCM_Q_SUSP = 16'h0202;
    localparam logic [FCM_DW-1:0] FCM_Q_ONE = 16'h0101;
    localparam logic [FCM_DW-1:0] FCM_Q_SCHEME = 16'h0404;
    localparam logic [FCM_DW-1:0] FCM_Q_ZERO = 16'h0000;
    localparam logic [FCM_DW-1:0] FCM_Q_ACCMIN = 16'hb5b5;
    localparam logic [FCM_DW-1:0] FCM_Q_ACCMAX = 16'hc5c5;
    localparam logic [FCM_DW-1:0] FCM_Q_BOOTB = 16'h0404;
    localparam logic [FCM_DW-1:0] FCM_Q_BOOTT = 16'h0505;
    localparam logic [7:0] FCM_PROT_LOW = 8'h02;
    localparam int FCM_TMO_BIT_LO = 5;
    localparam int FCM_TMO_BIT_HI = 13;
    localparam int FCM_ABT_BIT_LO = 1;
    localparam int FCM_ABT_BIT_HI = 9;
    // ****************************************
    // pin timing
    // ****************************************
    localparam int FCM_CLK_NS = 4;
    localparam int FCM_PHASE_NS = 40;
    localparam int FCM_PHASE_CYC = (FCM_PHASE_NS + FCM_CLK_NS - 1) / FCM_CLK_NS;
    typedef enum logic [1:0] {
        FCM_M_READ = 2'b00,
        FCM_M_SUSP = 2'b01,
        FCM_M_IDENT = 2'b10,
        FCM_M_QUERY = 2'b11
    } fcm_mode_t;
    typedef struct packed {
        logic ceN;
        logic weN;
        logic oeN;
        logic [FCM_AW-1:0] addr;
        logic [FCM_DW-1:0] dout;
        logic doe;
    } fcm_pins_t;
    typedef struct packed {
        logic [FCM_AW-1:0] addr;
        logic [FCM_DW-1:0] data;
        logic rd;
    } fcm_cycle_t;
endpackage : fcm_pkg

/* test/fcm_flash_model.sv */
// behavioural flash: command decoder, query table, identify and array reads
// assumes the host keeps write strobe and output enable apart; no clock at the pins
`timescale 1ns/1ps
module fcm_flash_model
    import fcm_pkg::*;
#(
    parameter logic [FCM_DW-1:0] MFR_CODE = 16'h00c3, // arbitrary value
    parameter logic [FCM_DW-1:0] DEV_CODE = 16'h2a00 // arbitrary value
) (
    input wire logic ceN,
    input wire logic weN,
    input wire logic oeN,
    input wire logic [FCM_AW-1:0] addr,
    input wire logic [FCM_DW-1:0] dqIn,
    input wire logic tmoReq,
    output logic [FCM_DW-1:0] dqOut
);
    logic [FCM_DW-1:0] qTab [17] = '{16'h5050, 16'h5252, 16'h4949, 16'h3131, 16'h3333,
        16'h0808, 16'h0202, 16'h0101, 16'h0101, 16'h0404, 16'h0000, 16'h0000, 16'h0101,
        16'hb5b5, 16'hc5c5, 16'h0404, 16'h0101};
    fcm_mode_t mode = FCM_M_READ;
    fcm_mode_t base = FCM_M_READ;
    logic fromIdent = 1'b0;
    logic armed = 1'b0;
    logic [1:0] step = 2'h0;
    logic [FCM_AW-1:0] aLat;
    logic [FCM_DW-1:0] val;
    logic [FCM_DW-1:0] held = 16'h0000;
    wire wrN = weN | ceN;
    wire [7:0] lo = addr[7:0];
    always @(negedge wrN) begin
        aLat = addr;
        armed = oeN;
    end
    always @(posedge wrN) begin
        if (armed) begin
            armed = 1'b0;
            if (dqIn[7:0] == 8'hf0) begin
                mode = (mode == FCM_M_QUERY && fromIdent) ? FCM_M_IDENT : base;
                fromIdent = 1'b0;
                step = 2'h0;
            end else if (dqIn == FCM_QUERY_DATA && aLat == FCM_QUERY_ADDR) begin
                fromIdent = (mode == FCM_M_IDENT);
                mode = FCM_M_QUERY;
            end else if (step == 2'h2 && dqIn == FCM_DEF_IDENT_D && mode != FCM_M_QUERY) begin
                mode = FCM_M_IDENT;
                step = 2'h0;
            end else if (dqIn == FCM_DEF_SUSPEND_D) begin
                mode = FCM_M_SUSP;
                base = FCM_M_SUSP;
            end else begin
                // out of order clears the unlock count to zero, even a first unlock write; the next first unlock write begins it again
                step = (step == 2'h0 && aLat == FCM_DEF_UNLOCK1_A) ? 2'h1 :
                    (step == 2'h1 && aLat == FCM_DEF_UNLOCK2_A) ? 2'h2 : 2'h0;
            end
        end
    end
    always_comb begin
        if (mode == FCM_M_QUERY)
            val = (lo >= 8'h40 && lo <= 8'h50) ? qTab[5'(lo - 8'h40)] : 16'h0000;
        else if (mode == FCM_M_IDENT)
            val = (lo == 8'h00) ? MFR_CODE : (lo == 8'h02) ? {15'h0, addr[FCM_AW-1]} * 16'h0101 :
                (lo == 8'h01 || lo == 8'h0e || lo == 8'h0f) ? DEV_CODE | {8'h00, lo} : 16'h0000;
        else
            val = (addr[15:0] ^ 16'h1111) | (tmoReq ? 16'h2020 : 16'h0000);
    end
    // a released bus shows the inverse of the last word, not a stale copy
    always @(posedge oeN) held = ~val;
    assign dqOut = (!ceN && !oeN) ? val : held;
endmodule : fcm_flash_model

/* test/fcm_host_props.sv */
// checker on the flash pins and register port of the host controller
// assumes one clock domain; sees only the ports of fcm_host
`timescale 1ns/1ps
module fcm_host_props
    import fcm_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [3:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdata,
    input wire logic flashCeN,
    input wire logic flashWeN,
    input wire logic flashOeN,
    input wire logic [FCM_AW-1:0] flashAddr,
    input wire logic [FCM_DW-1:0] flashDqOut,
    input wire logic flashDqOe,
    input wire logic [FCM_DW-1:0] flashDqIn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence weLow8; (!flashWeN)[*8]; endsequence
    sequence oeLow8; (!flashOeN)[*8]; endsequence
    chk_write_inhibit: assert property (!flashWeN |-> flashOeN && !flashCeN && flashDqOe)
        else $error("write strobe without select or with output enable");
    chk_read_release: assert property (!flashOeN |-> !flashDqOe && !flashCeN)
        else $error("host drives data during a read");
    chk_write_hold: assert property (
        !flashWeN && $past(!flashWeN) |-> $stable(flashAddr) && $stable(flashDqOut))
        else $error("address or data moved inside a write");
    chk_data_at_rise: assert property (
        $rose(flashWeN) |-> flashDqOe && $stable(flashDqOut) && !flashCeN)
        else $error("data not held at the write rise");
    chk_we_width: assert property ($fell(flashWeN) |-> weLow8)
        else $error("write strobe too short");
    chk_oe_width: assert property ($fell(flashOeN) |-> oeLow8)
        else $error("output enable too short");
    chk_select_first: assert property ($fell(flashCeN) |-> flashWeN && flashOeN)
        else $error("strobe fell with chip select");
    chk_idle_pins: assert property (flashCeN |-> flashWeN && flashOeN)
        else $error("strobe active while deselected");
    chk_rdata_hold: assert property (!$past(regRd) |-> $stable(regRdata))
        else $error("read data changed without a read");
endmodule : fcm_host_props
bind fcm_host fcm_host_props fcm_host_props_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .flashCeN(flashCeN), .flashWeN(flashWeN), .flashOeN(flashOeN), .flashAddr(flashAddr),
    .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn));

/* test/testbench.sv */
// self-checking bench: register port orders driving the host into a flash model
// assumes one 250 MHz clock; the model answers reads with no wait
`timescale 1ns/1ps
module testbench
    import fcm_pkg::*;
;
    logic clk = 1'b0, nrst = 1'b0, regWr = 1'b0, regRd = 1'b0, tmoReq = 1'b0;
    logic [3:0] regAddr = 4'h0;
    logic [31:0] regWdata = 32'h0, regRdata, v;
    logic flashCeN, flashWeN, flashOeN, flashDqOe;
    logic [FCM_AW-1:0] flashAddr;
    logic [FCM_DW-1:0] flashDqOut, devDq, flashDqIn;
    int mismatches = 0, testsRun = 0, cycles = 0;
    localparam logic [15:0] MFR = 16'h00c3; // arbitrary value
    localparam logic [15:0] DEV = 16'h2a00; // arbitrary value
    logic [15:0] qExp [17] = '{FCM_Q_P, FCM_Q_R, FCM_Q_I, FCM_Q_MAJ, FCM_Q_MIN, FCM_Q_UNLK,
        FCM_Q_SUSP, FCM_Q_ONE, FCM_Q_ONE, FCM_Q_SCHEME, FCM_Q_ZERO, FCM_Q_ZERO, FCM_Q_ONE,
        FCM_Q_ACCMIN, FCM_Q_ACCMAX, FCM_Q_BOOTB, FCM_Q_ONE};
    always #2 clk = ~clk;
    assign flashDqIn = flashDqOe ? flashDqOut : devDq;
    fcm_host fcm_host_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .flashCeN(flashCeN),
        .flashWeN(flashWeN), .flashOeN(flashOeN), .flashAddr(flashAddr),
        .flashDqOut(flashDqOut), .flashDqOe(flashDqOe), .flashDqIn(flashDqIn));
    fcm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) fcm_flash_model_inst (.ceN(flashCeN),
        .weN(flashWeN), .oeN(flashOeN), .addr(flashAddr), .dqIn(flashDqOut),
        .tmoReq(tmoReq), .dqOut(devDq));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        testsRun++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
        @(posedge clk);
    endtask : rd
    task automatic op(input logic [23:0] a, input logic [3:0] code);
        wr(FCM_REG_ADDR, {8'h00, a});
        wr(FCM_REG_CMD, {28'h0, code});
        v = 32'h1;
        for (int i = 0; i < 200 && v[FCM_STAT_BUSY] !== 1'b0; i++) rd(FCM_REG_STAT, v);
        chk("busy", 32'h0, {31'h0, v[FCM_STAT_BUSY]});
    endtask : op
    task automatic fread(input logic [23:0] a, input logic [31:0] exp, input string what);
        op(a, FCM_OP_READ);
        rd(FCM_REG_RDATA, v);
        chk(what, exp, v);
    endtask : fread
    task automatic mode(input fcm_mode_t exp, input string what);
        rd(FCM_REG_MODE, v);
        chk(what, {30'h0, exp}, {30'h0, v[5:4]});
    endtask : mode
    task automatic flag(input int bitNo, input logic exp, input string what);
        rd(FCM_REG_STAT, v);
        chk(what, {31'h0, exp}, {31'h0, v[bitNo]});
    endtask : flag
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize
    // ****************************************
    // hang guard, far above the expected run
    // ****************************************
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        mode(FCM_M_READ, "mode after reset");
        fread(24'h000123, 32'h00001032, "array word");
        op(FCM_QUERY_ADDR, FCM_OP_QUERY);
        mode(FCM_M_QUERY, "query mode");
        for (int i = 0; i < 17; i++) begin
            fread(FCM_Q_PRI0 + 24'(i), 32'(qExp[i]), "query");
        end
        op(24'habcdef, FCM_OP_RESET);
        mode(FCM_M_READ, "mode after reset cmd");
        fread(24'h000010, 32'h00001101, "array after reset");
        op(24'h000000, FCM_OP_IDENT);
        fread(24'h000000, {16'h0, MFR}, "maker code");
        fread(24'h000001, {16'h0, DEV | 16'h0001}, "device code 1");
        fread(24'h00000e, {16'h0, DEV | 16'h000e}, "device code 2");
        fread(24'h00000f, {16'h0, DEV | 16'h000f}, "device code 3");
        fread(24'h800002, 32'h00000101, "protected sector");
        fread(24'h000002, 32'h00000000, "open sector");
        op(FCM_QUERY_ADDR, FCM_OP_QUERY);
        fread(24'h000040, {16'h0, FCM_Q_P}, "query from identify");
        op(24'h000000, FCM_OP_RESET);
        fread(24'h000000, {16'h0, MFR}, "back to identify");
        wr(FCM_REG_MODE, 32'h1);
        op(24'h000000, FCM_OP_RESET);
        fread(24'h000000, {16'h0, MFR}, "reset ignored in op");
        flag(FCM_STAT_ERR, 1'b1, "refused reset flag");
        // the polled maker code carries the low abort bit, so the flag must be up
        flag(FCM_STAT_ABT, MFR[FCM_ABT_BIT_LO], "abort flag from poll");
        wr(FCM_REG_STAT, 32'h8);
        wr(FCM_REG_MODE, 32'h0);
        op(24'h000000, FCM_OP_RESET);
        flag(FCM_STAT_ERR, 1'b1, "reset refused on abort");
        wr(FCM_REG_STAT, 32'h8);
        op(24'h000000, FCM_OP_ABORT_RST);
        flag(FCM_STAT_ABT, 1'b0, "abort flag cleared");
        fread(24'h000000, 32'h00001111, "array after identify");
        wr(FCM_REG_MODE, 32'h1);
        tmoReq <= 1'b1;
        fread(24'h000040, 32'h00003171, "timeout poll");
        tmoReq <= 1'b0;
        flag(FCM_STAT_TMO, 1'b1, "timeout flag");
        wr(FCM_REG_MODE, 32'h0);
        op(24'h000000, FCM_OP_RESET);
        flag(FCM_STAT_TMO, 1'b0, "timeout cleared");
        wr(FCM_REG_CMD, 32'h0000000f);
        flag(FCM_STAT_ERR, 1'b1, "illegal order flag");
        wr(FCM_REG_STAT, 32'h8);
        wr(4'hf, 32'hffffffff);
        flag(FCM_STAT_ERR, 1'b0, "illegal flag cleared");
        wr(FCM_REG_DATA, {16'h0, FCM_QUERY_DATA});
        rd(FCM_REG_DATA, v);
        chk("data register", {16'h0, FCM_QUERY_DATA}, v);
        op(FCM_QUERY_ADDR, FCM_OP_WRITE);
        fread(FCM_Q_PRI0, {16'h0, FCM_Q_P}, "query by raw write");
        op(24'h000000, FCM_OP_RESET);
        fread(24'h000010, 32'h00001101, "array after raw query");
        op(24'h000000, FCM_OP_SUSPEND);
        mode(FCM_M_SUSP, "suspend mode");
        op(24'h000000, FCM_OP_IDENT);
        fread(24'h000000, {16'h0, MFR}, "identify in suspend");
        op(24'h000000, FCM_OP_RESET);
        mode(FCM_M_SUSP, "suspend after identify");
        fread(24'h000020, 32'h00001131, "suspend read");
        summarize();
    end
endmodule : testbench
